// ---- hdl/lass_pkg.sv ----
// Shared constants of the linear array scan sequencer: array geometry,
// setup clock count and the timing figures of the scan link.
// Assumes a 250 MHz system clock on both ends of the link.
package lass_pkg;
  // ==========================================================
  // Array geometry
  localparam int unsigned N_PIX      = 768;
  localparam int unsigned PIX_W      = 12;
  localparam int unsigned SETUP_CLKS = 18;
  // ==========================================================
  // Timing
  localparam int unsigned SYS_MHZ       = 250;
  localparam int unsigned SYS_NS        = 4;
  localparam int unsigned T_CLK_W_NS    = 50;
  localparam int unsigned F_SCAN_MAX_MHZ = 8;
  localparam int unsigned T_CT_US       = 20;
  localparam int unsigned T_INT_MAX_MS  = 100;
  localparam int unsigned CLK_W_CYC  = (T_CLK_W_NS + SYS_NS - 1) / SYS_NS;
  localparam int unsigned PERIOD_MIN_CYC = (SYS_MHZ + F_SCAN_MAX_MHZ - 1)
                                           / F_SCAN_MAX_MHZ;
  localparam int unsigned HALF_DEF_CYC = 16;
  localparam int unsigned CT_CYC      = T_CT_US * SYS_MHZ;
  localparam int unsigned INT_MAX_CYC = T_INT_MAX_MS * 1000 * SYS_MHZ;
endpackage : lass_pkg

// ---- hdl/lass_link_if.sv ----
// Scan link between a scan controller and one array section.
// The controller drives clock, start and hold; the sensor drives the
// pixel output and its enable (a released output keeps its last value).
`timescale 1ns/1ns
`default_nettype none
interface lass_link_if #(parameter int W = 12);
  logic         scan_clk;
  logic         start;
  logic         hold;
  logic [W-1:0] pixel_analog_out;
  logic         pixel_analog_oe;

  modport sensor (input scan_clk, input start, input hold,
                  output pixel_analog_out, output pixel_analog_oe);
  modport ctrl   (output scan_clk, output start, output hold,
                  input pixel_analog_out, input pixel_analog_oe);
endinterface : lass_link_if
`default_nettype wire

// ---- hdl/lass_sensor.sv ----
// Sensor end of the scan link: integrators, parallel hold and the
// shift-out sequence of one array section, in a digital stand-in.
// Assumes scan_clk, start and hold are synchronous to sys_clk_in and
// that scan_clk high and low phases each last at least two cycles.
`timescale 1ns/1ns
`default_nettype none
module lass_sensor
  import lass_pkg::*;
#(
  parameter int N = N_PIX,
  parameter int W = PIX_W
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  lass_link_if.sensor               link,
  input  wire logic                 light_valid_in,
  input  wire logic [$clog2(N)-1:0] light_idx_in,
  input  wire logic [W-1:0]         light_in,
  output logic                      integrator_reset_switch_out,
  output logic [$clog2(N+2)-1:0]    readout_cnt_out,
  output logic [$clog2(N+2)-1:0]    pixel_sample_switch_out
);
  localparam int CW = $clog2(N + 2);

  initial begin
    if (N <= SETUP_CLKS || W < 1) begin
      $error("lass_sensor: N must exceed the setup clock count");
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [N-1:0][W-1:0] integ;
    logic [N-1:0][W-1:0] held;
    logic                sclk_d;
    logic [CW-1:0]       cnt;
    logic [W-1:0]        dout;
    logic                oe;
  } lass_sns_t;

  lass_sns_t s_r;
  lass_sns_t s_nxt;

  function automatic logic [W-1:0] sat_add(input logic [W-1:0] a,
                                           input logic [W-1:0] b);
    logic [W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[W] ? {W{1'b1}} : sum[W-1:0];
  endfunction : sat_add

  logic rise;
  logic ireset;

  // Reset switch closed from the start edge through the 18th edge
  assign ireset = (s_r.cnt != '0) &&
                  (s_r.cnt <= CW'(SETUP_CLKS));
  assign rise   = link.scan_clk & ~s_r.sclk_d;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.sclk_d = link.scan_clk;
    // Light keeps integrating while the held frame shifts out, except while ireset is high
    if (light_valid_in && !ireset &&
        (int'(light_idx_in) < N)) begin
      s_nxt.integ[light_idx_in] = sat_add(s_r.integ[light_idx_in],
                                          light_in);
    end
    if (ireset) begin
      s_nxt.integ = '0;
    end
    if (rise) begin
      // Hold snapshots every integrator at once; the span since the
      // last integration start is the integration period
      if (link.hold) begin
        s_nxt.held = s_r.integ;
      end
      if (link.start) begin
        s_nxt.cnt  = CW'(1);
        s_nxt.oe   = 1'b1;
        s_nxt.dout = link.hold ? s_r.integ[0] : s_r.held[0];
      end else if (s_r.cnt != '0) begin
        if (s_r.cnt >= CW'(N)) begin
          s_nxt.cnt = '0;
          s_nxt.oe  = 1'b0;
        end else begin
          s_nxt.cnt  = s_r.cnt + CW'(1);
          s_nxt.dout = s_r.held[s_r.cnt];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign link.pixel_analog_out   = s_r.dout;
  assign link.pixel_analog_oe    = s_r.oe;
  assign integrator_reset_switch_out = ireset;
  assign readout_cnt_out         = s_r.cnt;

  // Count of pixels back on their sampling capacitor: none during the
  // reset phase, 18 at once at clock 19, then one per clock
  always_comb begin
    if (s_r.cnt == '0) begin
      pixel_sample_switch_out = CW'(N);
    end else if (s_r.cnt <= CW'(SETUP_CLKS)) begin
      pixel_sample_switch_out = '0;
    end else begin
      pixel_sample_switch_out = s_r.cnt - CW'(1);
    end
  end
endmodule : lass_sensor
`default_nettype wire

// ---- hdl/lass_ctrl.sv ----
// Controller end of the scan link: makes the scan clock by division,
// issues tied start/hold pulses, samples each pixel of a primed scan mid high phase and
// queues it in a two-entry buffer toward the user.
// Assumes one sys_clk_in domain shared with the sensor end.
`timescale 1ns/1ns
`default_nettype none
module lass_ctrl
  import lass_pkg::*;
#(
  parameter int N        = N_PIX,
  parameter int W        = PIX_W,
  parameter int HALF     = HALF_DEF_CYC,
  parameter int CT       = CT_CYC,
  parameter int INT_MAX  = INT_MAX_CYC
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  lass_link_if.ctrl                 link,
  input  wire logic                 scan_req_in,
  input  wire logic [31:0]          extra_wait_in,
  output logic                      scan_ready_out,
  output logic                      primed_out,
  output logic                      pix_valid_out,
  input  wire logic                 pix_ready_in,
  output logic [$clog2(N)-1:0]      pix_idx_out,
  output logic [W-1:0]              pix_data_out
);
  localparam int CW = $clog2(N + 2);
  localparam int IW = $clog2(N);
  localparam int SCAN_CYC = 2 * HALF * (N + 2);
  localparam logic [31:0] EXT_MAX = 32'(INT_MAX - CT - SCAN_CYC);

  initial begin
    if (HALF < CLK_W_CYC || 2 * HALF < PERIOD_MIN_CYC ||
        INT_MAX <= CT + SCAN_CYC) begin
      $error("lass_ctrl: scan clock or wait figures out of range");
    end
  end

  // ==========================================================
  // State
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_HI    = 5'b00100,
    ST_LO    = 5'b01000,
    ST_WAIT  = 5'b10000
  } lass_st_t;

  typedef struct packed {
    lass_st_t            st;
    logic [31:0]         tmr;
    logic [31:0]         ext;
    logic [CW-1:0]       ecnt;
    logic                sclk;
    logic                si;
    logic                primed;
    logic [1:0][IW+W-1:0] fifo;
    logic                rd;
    logic [1:0]          cnt;
  } lass_ctl_t;

  lass_ctl_t s_r;
  lass_ctl_t s_nxt;

  logic push;
  logic pop;

  assign pop  = (s_r.cnt != 2'h0) && pix_ready_in;
  // Converter samples in the middle of the high phase, well inside the
  // period for which the pixel stands on the output
  assign push = (s_r.st == ST_HI) && (s_r.tmr == 32'(HALF / 2)) &&
                link.pixel_analog_oe && s_r.primed;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.tmr = s_r.tmr + 32'h1;
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.tmr = '0;
        if (scan_req_in) begin
          s_nxt.st  = ST_SETUP;
          s_nxt.si  = 1'b1;
          s_nxt.ext = (extra_wait_in > EXT_MAX) ? EXT_MAX
                                                : extra_wait_in;
        end
      end
      ST_SETUP: begin
        if (s_r.tmr == 32'(HALF - 1)) begin
          s_nxt.st   = ST_HI;
          s_nxt.sclk = 1'b1;
          s_nxt.tmr  = '0;
          s_nxt.ecnt = CW'(1);
        end
      end
      ST_HI: begin
        if (s_r.tmr == 32'(HALF - 1)) begin
          s_nxt.st   = ST_LO;
          s_nxt.sclk = 1'b0;
          s_nxt.si   = 1'b0;
          s_nxt.tmr  = '0;
        end
      end
      ST_LO: begin
        if (s_r.tmr >= 32'(HALF - 1)) begin
          s_nxt.tmr = 32'(HALF - 1);
          if (s_r.ecnt == CW'(N + 1)) begin
            s_nxt.st  = ST_WAIT;
            s_nxt.tmr = '0;
          end else if (s_r.cnt == 2'h0 ||
                       (s_r.cnt == 2'h1 && pop)) begin
            // Clock edge only when the buffer can take the next pixel
            s_nxt.st   = ST_HI;
            s_nxt.sclk = 1'b1;
            s_nxt.tmr  = '0;
            s_nxt.ecnt = s_r.ecnt + CW'(1);
          end
        end
      end
      ST_WAIT: begin
        // Charge transfer time, then the user's extra integration time
        if (s_r.tmr >= 32'(CT - 1) + s_r.ext) begin
          s_nxt.st     = ST_IDLE;
          s_nxt.primed = 1'b1;
          s_nxt.tmr    = '0;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (pop) begin
      s_nxt.rd = ~s_r.rd;
    end
    if (push) begin
      s_nxt.fifo[s_r.rd ^ s_r.cnt[0]] =
        {IW'(s_r.ecnt - CW'(1)), link.pixel_analog_out};
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r    <= '0;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign link.scan_clk = s_r.sclk;
  assign link.start    = s_r.si;
  assign link.hold     = s_r.si;
  assign scan_ready_out = (s_r.st == ST_IDLE);
  assign primed_out    = s_r.primed;
  assign pix_valid_out = (s_r.cnt != 2'h0);
  assign pix_idx_out   = s_r.fifo[s_r.rd][IW+W-1:W];
  assign pix_data_out  = s_r.fifo[s_r.rd][W-1:0];
endmodule : lass_ctrl
`default_nettype wire

// ---- sim/lass_link_checker.sv ----
// Assertions on the scan link between the controller and sensor ends.
// Assumes one clock domain; the bench places it beside the link.
`timescale 1ns/1ns
`default_nettype none
module lass_link_checker #(
  parameter int N       = 24,
  parameter int CT      = 16,
  parameter int INT_MAX = 4000,
  parameter int W       = 8
) (
  input wire logic         sys_clk_in,
  input wire logic         rst_n_in,
  input wire logic         scan_clk,
  input wire logic         start,
  input wire logic         hold,
  input wire logic [W-1:0] pixel_analog_out,
  input wire logic         pixel_analog_oe
);
  // One cycle of slack: the wait may be counted from the edge itself
  localparam int CT_MIN = CT - 1;
  logic        clk_d_r;
  logic        rise;
  logic [15:0] rise_cnt_r;
  logic [31:0] since_r;
  logic [31:0] gap_r;
  assign rise = scan_clk & ~clk_d_r;
  // ==========================================================
  // Helper counters
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_d_r    <= 1'b0;
      rise_cnt_r <= 16'h0;
      since_r    <= 32'(CT);
      gap_r      <= 32'h0;
    end else begin
      clk_d_r    <= scan_clk;
      rise_cnt_r <= !rise ? rise_cnt_r : start ? 16'h1 : rise_cnt_r + 16'h1;
      since_r    <= rise ? 32'h0 : since_r + 32'h1;
      gap_r      <= (rise && start) ? 32'h0 : gap_r + 32'h1;
    end
  end
  // ==========================================================
  // Link rules
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_go;
    start && rise;
  endsequence
  sequence s_next;
    rise && !start && rise_cnt_r < 16'(N);
  endsequence
  hold_tied_a: assert property (hold == start)
    else $error("hold differs from start");
  start_edge_a: assert property ($rose(start) |-> !scan_clk)
    else $error("start rose with scan clock high");
  start_drop_a: assert property ($fell(scan_clk) |-> !start)
    else $error("start still high at clock fall");
  first_pixel_a: assert property (s_go |=> pixel_analog_oe)
    else $error("first pixel not driven");
  pixel_step_a: assert property (s_next |=> pixel_analog_oe)
    else $error("output released inside scan");
  hiz_end_a: assert property (rise && !start &&
    rise_cnt_r == 16'(N) |=> !pixel_analog_oe)
    else $error("output not released after last clock");
  pixel_stands_a: assert property (pixel_analog_oe &&
    $past(pixel_analog_oe) && !$past(rise) |-> $stable(pixel_analog_out))
    else $error("pixel changed inside clock period");
  scan_count_a: assert property (s_go |->
    rise_cnt_r == 16'h0 || rise_cnt_r == 16'(N + 1))
    else $error("wrong clock count between starts");
  charge_wait_a: assert property ($rose(start) |->
    since_r >= 32'(CT_MIN)) else $error("charge wait too short");
  start_gap_a: assert property (s_go |-> gap_r <= 32'(INT_MAX))
    else $error("start spacing too long");
  idle_clock_a: assert property (rise |-> start || pixel_analog_oe)
    else $error("scan clock rose while idle");
  clk_high_a: assert property ($rose(scan_clk) |-> scan_clk [*8])
    else $error("scan clock high phase short");
  clk_low_a: assert property ($fell(scan_clk) |-> !scan_clk [*8])
    else $error("scan clock low phase short");
endmodule : lass_link_checker
`default_nettype wire

// ---- sim/test_linear_array_scan_sequencer.sv ----
// Bench: both ends joined by the link, random light and output stalls,
// pixel stream and sensor switches compared with a bench model.
// Assumes the package, link interface and both ends compile first.
`timescale 1ns/1ns
`default_nettype none
module test_linear_array_scan_sequencer;
  localparam int N = 24, W = 8, HALF = 16, CT = 16, INT_MAX = 4000;
  localparam int IW = $clog2(N), CW = $clog2(N + 2), FRAMES = 4;
  logic          sys_clk_in, rst_n_in, light_valid_in, scan_req_in;
  logic          pix_ready_in, irs, scan_ready, primed, pix_valid, sclk_d;
  logic [IW-1:0] light_idx_in, pix_idx;
  logic [W-1:0]  light_in, pix_data;
  logic [CW-1:0] rcnt, sws;
  logic [31:0]   extra_wait_in, lfsr_r;
  logic [W-1:0]  acc [N];
  logic [W-1:0]  exp_px [N];
  int err_count, comparisons, rc, hi_cnt, lo_cnt, pops, scans, stall;
  lass_link_if #(.W(W)) lass_link_if_i ();
  lass_sensor #(.N(N), .W(W)) lass_sensor_i (.sys_clk_in, .rst_n_in,
    .link(lass_link_if_i.sensor), .light_valid_in, .light_idx_in,
    .light_in, .integrator_reset_switch_out(irs), .readout_cnt_out(rcnt),
    .pixel_sample_switch_out(sws));
  lass_ctrl #(.N(N), .W(W), .HALF(HALF), .CT(CT), .INT_MAX(INT_MAX))
    lass_ctrl_i (.sys_clk_in, .rst_n_in, .link(lass_link_if_i.ctrl),
    .scan_req_in, .extra_wait_in, .scan_ready_out(scan_ready),
    .primed_out(primed), .pix_valid_out(pix_valid), .pix_ready_in,
    .pix_idx_out(pix_idx), .pix_data_out(pix_data));
  lass_link_checker #(.N(N), .CT(CT), .INT_MAX(INT_MAX), .W(W))
    lass_link_checker_i (.sys_clk_in, .rst_n_in,
    .scan_clk(lass_link_if_i.scan_clk), .start(lass_link_if_i.start),
    .hold(lass_link_if_i.hold),
    .pixel_analog_out(lass_link_if_i.pixel_analog_out),
    .pixel_analog_oe(lass_link_if_i.pixel_analog_oe));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr_next
  function automatic logic [W-1:0] sat_add(input logic [W-1:0] a, b);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[W] ? '1 : s[W-1:0];
  endfunction : sat_add
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Model, monitor and random drive
  always @(posedge sys_clk_in) begin
    if (rst_n_in) begin
      // Light while integrators are held in reset must be lost
      if (light_valid_in && !(rc >= 1 && rc <= 18))
        acc[light_idx_in] = sat_add(acc[light_idx_in], light_in);
      if (lass_link_if_i.scan_clk && !sclk_d) begin
        if (lass_link_if_i.start) begin
          rc = 1;
          scans++;
          exp_px = acc;
          foreach (acc[i]) acc[i] = '0;
        end else rc++;
      end
      sclk_d = lass_link_if_i.scan_clk;
      hi_cnt = sclk_d ? hi_cnt + 1 : 0;
      lo_cnt = sclk_d ? 0 : lo_cnt + 1;
      if (hi_cnt == 4 && rc > 0) begin
        // After edge N+1 the scan is over: counter idle, all sampling
        check("readout_cnt", 32'(rcnt), 32'(rc > N ? 0 : rc));
        check("int_reset", 32'(irs), 32'(rc <= 18));
        check("sample_sw", 32'(sws),
              32'(rc > N ? N : rc <= 18 ? 0 : rc - 1));
      end
      if (pix_valid && pix_ready_in) begin
        if (pops == 0) check("primed", 32'(primed), 32'h1);
        check("pix_idx", 32'(pix_idx), 32'(pops % N));
        check("pix_data", 32'(pix_data), 32'(exp_px[pops % N]));
        pops++;
      end
      // Long stall holds one pixel in the buffer; the scan clock must wait low
      if (pops == N + 5) stall++;
      if (stall == 149) begin
        check("stall_valid", 32'(pix_valid), 32'h1);
        check("stall_clk", 32'(lass_link_if_i.scan_clk), 32'h0);
      end
      lfsr_r = lfsr_next(lfsr_r);
      pix_ready_in <= (lfsr_r[2] | lfsr_r[3]) && !(pops == N + 5 && stall < 150);
      light_valid_in <= lfsr_r[0] && !lass_link_if_i.start && lo_cnt >= 3
                        && lo_cnt <= HALF - 4;
      light_idx_in <= IW'(lfsr_r[12:8] % N);
      light_in <= lfsr_r[23:16];
      extra_wait_in <= {26'h0, lfsr_r[29:24]};
      scan_req_in <= scans < FRAMES + 1;
    end
  end
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    {rst_n_in, light_valid_in, scan_req_in, pix_ready_in, sclk_d} = 5'h0;
    light_idx_in = '0;
    light_in = '0;
    extra_wait_in = 32'h0;
    lfsr_r = 32'h4276fb9b;
    foreach (acc[i]) acc[i] = '0;
    repeat (8) @(posedge sys_clk_in);
    check("ready_rst", 32'(scan_ready), 32'h1);
    check("primed_rst", 32'(primed), 32'h0);
    check("oe_rst", 32'(lass_link_if_i.pixel_analog_oe), 32'h0);
    check("sw_rst", 32'(sws), 32'(N));
    rst_n_in <= 1'b1;
    wait (pops == FRAMES * N);
    repeat (200) @(posedge sys_clk_in);
    check("idle_oe", 32'(lass_link_if_i.pixel_analog_oe), 32'h0);
    check("idle_clk", 32'(lass_link_if_i.scan_clk), 32'h0);
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    err_count++;
    stop_test();
  end
endmodule : test_linear_array_scan_sequencer
`default_nettype wire
